/* design/etcu_map.svh */
`ifndef ETCU_MAP_SVH
`define ETCU_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define ETCU_OFS_A_RISE   8'h40
`define ETCU_OFS_A_FALL   8'h41
`define ETCU_OFS_B_RISE   8'h42
`define ETCU_OFS_B_FALL   8'h43
`define ETCU_OFS_CFG      8'h44
`define ETCU_OFS_FLAGS    8'h45

// ****************************************************************
// reset values
// ****************************************************************
`define ETCU_RST_BYTE     8'h00
`define ETCU_RST_FLAGS    4'h0
`define ETCU_RST_CFG      8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define ETCU_CFG_HOLD_BIT 7
`define ETCU_CFG_PS_HI    6
`define ETCU_CFG_PS_LO    4
`define ETCU_CFG_IE_HI    3
`define ETCU_CFG_IE_LO    0
`define ETCU_FLG_A_RISE   0
`define ETCU_FLG_A_FALL   1
`define ETCU_FLG_B_RISE   2
`define ETCU_FLG_B_FALL   3
`define ETCU_GIE_A_BIT    4
`define ETCU_GIE_B_BIT    5

// ****************************************************************
// prescale codes and timing counts
// ****************************************************************
`define ETCU_PS_DIV1      3'h0
`define ETCU_PS_DIV2      3'h1
`define ETCU_PS_DIV4      3'h2
`define ETCU_PS_DIV8      3'h3
`define ETCU_PS_DIV16     3'h4
`define ETCU_SYNC_FILL    2'h3

`endif

/* design/etcu_pkg.sv */
`default_nettype none

package etcu_pkg;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef struct packed {
      logic rise;
      logic fall;
   } etcu_edge_t;

   typedef struct packed {
      logic       hold;
      logic [2:0] prescale;
      logic [3:0] int_en;
   } etcu_cfg_t;

   typedef enum logic [2:0] {
      ETCU_REG_NONE,
      ETCU_REG_A_RISE,
      ETCU_REG_A_FALL,
      ETCU_REG_B_RISE,
      ETCU_REG_B_FALL,
      ETCU_REG_CFG,
      ETCU_REG_FLAGS
   } etcu_reg_t;

endpackage : etcu_pkg

`default_nettype wire

/* design/etcu_pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
`include "etcu_map.svh"

module etcu_pin_sync (
   // clock, reset, enable
   input  wire logic           i_mclk,
   input  wire logic           i_reset,
   input  wire logic           i_ce,
   // pin
   input  wire logic           i_pin,
   // edge events
   output var etcu_pkg::etcu_edge_t o_edge
);

   logic       meta_r;
   logic       mid_r;
   logic       late_r;
   logic       level_r;
   logic [1:0] fill_r;
   logic       agree;

   // ****************************************************************
   // three-stage synchroniser
   // ****************************************************************
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         meta_r <= 1'b0;
         mid_r  <= 1'b0;
         late_r <= 1'b0;
      end else if (i_ce) begin
         meta_r <= i_pin;
         mid_r  <= meta_r;
         late_r <= mid_r;
      end
   end

   assign agree = (mid_r == late_r);

   // pipeline fill: the first stable level after reset is no edge
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         fill_r <= 2'h0;
      end else if (i_ce && fill_r != `ETCU_SYNC_FILL) begin
         fill_r <= fill_r + 2'h1;
      end
   end

   // during fill the baseline follows the level the last stage takes next,
   // so a pin already high at release gives no false edge
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         level_r <= 1'b0;
      end else if (i_ce && fill_r != `ETCU_SYNC_FILL) begin
         level_r <= mid_r;
      end else if (i_ce && agree) begin
         level_r <= late_r;
      end
   end

   // ****************************************************************
   // edge detect on agreed samples
   // ****************************************************************
   always_comb begin
      o_edge.rise = 1'b0;
      o_edge.fall = 1'b0;
      if (agree && fill_r == `ETCU_SYNC_FILL && late_r != level_r) begin
         o_edge.rise = late_r;
         o_edge.fall = ~late_r;
      end
   end

endmodule : etcu_pin_sync

`default_nettype wire

/* design/etcu_top.sv */
// Operation
// [R01] Two channels: A on pin 0, B on pin 1, each rising and falling.
// [R02] A detected edge copies an 8-bit timer slice into its time register.
// [R03] Prescale config bits 6:4 pick timer bits 7:0 up to 11:4.
// [R04] The four time registers are read-only; writes change nothing.
// [R05] Flags 3:0 set by A rise, A fall, B rise, B fall; 7:4 zero.
// [R06] Reading a time register clears only its own flag.
// [R07] Hold bit 7 set keeps the first edge time until that register is read.
// [R08] Hold clear, the default, lets every edge overwrite the register.
// [R09] One hold bit governs all four time registers together.
// [R10] Config bits 3:0 enable interrupts per event; 1 enables.
// [R11] A events share request A; B events share request B.
// [R12] A request reaches out only with its global interrupt enable set.
// [R13] Firmware checks both flags of a channel to find the cause.
// [R14] Time source is the shared 12-bit free-running microsecond timer.
// [R15] Global enable bit 4 gates channel A, bit 5 gates channel B.
// [R16] Pins are synchronised, edges from samples; codes 101-111 act as 100.
// [R17] Reset clears time registers, flags, enables, prescale and hold.
`timescale 1ns/100ps
`default_nettype none
`include "etcu_map.svh"

module etcu_top (
   // clock, reset, enable
   input  wire logic        i_mclk,
   input  wire logic        i_reset,
   input  wire logic        i_ce,
   // capture pins
   input  wire logic [1:0]  i_pin,
   // shared timer and global interrupt enables
   input  wire logic [11:0] i_timer,
   input  wire logic [7:0]  i_global_ie,
   // register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   // interrupt requests
   output logic             o_irq_a,
   output logic             o_irq_b
);

   // ****************************************************************
   // functions
   // ****************************************************************
   function automatic etcu_pkg::etcu_reg_t etcu_decode(
      input logic [7:0] addr
   );
      etcu_pkg::etcu_reg_t sel;
      sel = etcu_pkg::ETCU_REG_NONE;
      if (addr == `ETCU_OFS_A_RISE) begin
         sel = etcu_pkg::ETCU_REG_A_RISE;
      end else if (addr == `ETCU_OFS_A_FALL) begin
         sel = etcu_pkg::ETCU_REG_A_FALL;
      end else if (addr == `ETCU_OFS_B_RISE) begin
         sel = etcu_pkg::ETCU_REG_B_RISE;
      end else if (addr == `ETCU_OFS_B_FALL) begin
         sel = etcu_pkg::ETCU_REG_B_FALL;
      end else if (addr == `ETCU_OFS_CFG) begin
         sel = etcu_pkg::ETCU_REG_CFG;
      end else if (addr == `ETCU_OFS_FLAGS) begin
         sel = etcu_pkg::ETCU_REG_FLAGS;
      end
      return sel;
   endfunction : etcu_decode

   function automatic logic [7:0] etcu_slice(
      input logic [11:0] t,
      input logic [2:0]  ps
   );
      logic [7:0] s;
      case (ps)
         `ETCU_PS_DIV1: s = t[7:0];
         `ETCU_PS_DIV2: s = t[8:1];
         `ETCU_PS_DIV4: s = t[9:2];
         `ETCU_PS_DIV8: s = t[10:3];
         default:       s = t[11:4];
      endcase
      return s;
   endfunction : etcu_slice

   // ****************************************************************
   // declarations
   // ****************************************************************
   etcu_pkg::etcu_edge_t edge_w [2];
   etcu_pkg::etcu_cfg_t  cfg_r;
   etcu_pkg::etcu_reg_t  sel;
   logic [7:0]           cap_r [4];
   logic [3:0]           flag_r;
   logic [3:0]           flag_nxt;
   logic [3:0]           event_w;
   logic [3:0]           rd_clr;
   logic [3:0]           cap_ok;
   logic [7:0]           slice_w;
   logic [7:0]           rdata_nxt;
   logic                 irq_a_nxt;
   logic                 irq_b_nxt;

   // ****************************************************************
   // pin synchronisers and edge detect
   // ****************************************************************
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      etcu_pin_sync u_sync (                                   // [R01] [R16]
         .i_mclk  (i_mclk),
         .i_reset (i_reset),
         .i_ce    (i_ce),
         .i_pin   (i_pin[ch]),
         .o_edge  (edge_w[ch])
      );
   end

   always_comb begin
      event_w[`ETCU_FLG_A_RISE] = edge_w[0].rise;               // [R01]
      event_w[`ETCU_FLG_A_FALL] = edge_w[0].fall;
      event_w[`ETCU_FLG_B_RISE] = edge_w[1].rise;
      event_w[`ETCU_FLG_B_FALL] = edge_w[1].fall;
   end

   // ****************************************************************
   // address decode
   // ****************************************************************
   assign sel = etcu_decode(i_addr);

   always_comb begin
      rd_clr = 4'h0;
      if (i_rd) begin                                           // [R06]
         rd_clr[`ETCU_FLG_A_RISE] = (sel == etcu_pkg::ETCU_REG_A_RISE);
         rd_clr[`ETCU_FLG_A_FALL] = (sel == etcu_pkg::ETCU_REG_A_FALL);
         rd_clr[`ETCU_FLG_B_RISE] = (sel == etcu_pkg::ETCU_REG_B_RISE);
         rd_clr[`ETCU_FLG_B_FALL] = (sel == etcu_pkg::ETCU_REG_B_FALL);
      end
   end

   // ****************************************************************
   // configuration register
   // ****************************************************************
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         cfg_r <= etcu_pkg::etcu_cfg_t'(`ETCU_RST_CFG);        // [R17]
      end else if (i_ce && i_wr && sel == etcu_pkg::ETCU_REG_CFG) begin
         cfg_r <= etcu_pkg::etcu_cfg_t'(i_wdata);              // [R10]
      end
   end

   // ****************************************************************
   // capture registers
   // ****************************************************************
   assign slice_w = etcu_slice(i_timer, cfg_r.prescale);        // [R03] [R14]

   // hold blocks a capture only while that register's flag is unread
   assign cap_ok = event_w                                      // [R08]
                   & ~({4{cfg_r.hold}} & flag_r);               // [R07] [R09]

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         for (int i = 0; i < 4; i++) begin
            cap_r[i] <= `ETCU_RST_BYTE;                        // [R17]
         end
      end else if (i_ce) begin
         for (int i = 0; i < 4; i++) begin
            if (cap_ok[i]) begin
               cap_r[i] <= slice_w;                            // [R02] [R04]
            end
         end
      end
   end

   // ****************************************************************
   // event flags
   // ****************************************************************
   // a new event wins over a read clear in the same cycle
   assign flag_nxt = event_w | (flag_r & ~rd_clr);              // [R05] [R06]

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         flag_r <= `ETCU_RST_FLAGS;                            // [R17]
      end else if (i_ce) begin
         flag_r <= flag_nxt;
      end
   end

   // ****************************************************************
   // read data
   // ****************************************************************
   always_comb begin
      rdata_nxt = 8'h00;
      if (i_rd) begin
         case (sel)
            etcu_pkg::ETCU_REG_A_RISE: rdata_nxt = cap_r[0];
            etcu_pkg::ETCU_REG_A_FALL: rdata_nxt = cap_r[1];
            etcu_pkg::ETCU_REG_B_RISE: rdata_nxt = cap_r[2];
            etcu_pkg::ETCU_REG_B_FALL: rdata_nxt = cap_r[3];
            etcu_pkg::ETCU_REG_CFG:    rdata_nxt = cfg_r;
            etcu_pkg::ETCU_REG_FLAGS:  rdata_nxt = {4'h0, flag_r}; // [R05]
            default:                   rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_rdata <= 8'h00;
      end else if (i_ce) begin
         o_rdata <= rdata_nxt;
      end
   end

   // ****************************************************************
   // interrupt requests
   // ****************************************************************
   assign irq_a_nxt = i_global_ie[`ETCU_GIE_A_BIT] & // [R12] [R15]
                      |(flag_r[1:0] & cfg_r.int_en[1:0]);       // [R10] [R11]
   assign irq_b_nxt = i_global_ie[`ETCU_GIE_B_BIT] & // [R12] [R15]
                      |(flag_r[3:2] & cfg_r.int_en[3:2]);       // [R10] [R11]

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_irq_a <= 1'b0;
         o_irq_b <= 1'b0;
      end else if (i_ce) begin
         o_irq_a <= irq_a_nxt;
         o_irq_b <= irq_b_nxt;
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   a_capture_value: assert property (                           // [R02]
      @(posedge i_mclk) disable iff (i_reset)
      (i_ce && cap_ok[0]) |=> cap_r[0] == $past(slice_w))
      else $error("a rise time not captured from timer slice");

   a_prescale_top: assert property (                            // [R03] [R16]
      @(posedge i_mclk) disable iff (i_reset)
      (i_ce && cap_ok[3] && cfg_r.prescale >= `ETCU_PS_DIV16)
      |=> cap_r[3] == $past(i_timer[11:4]))
      else $error("high prescale code did not select timer bits 11:4");

   a_time_readonly: assert property (                           // [R04]
      @(posedge i_mclk) disable iff (i_reset)
      (i_wr && sel == etcu_pkg::ETCU_REG_B_RISE && !cap_ok[2])
      |=> $stable(cap_r[2]))
      else $error("write changed a time register");

   a_flag_set: assert property (                                // [R05]
      @(posedge i_mclk) disable iff (i_reset)
      (i_ce && event_w != 4'h0)
      |=> (flag_r & $past(event_w)) == $past(event_w))
      else $error("event did not set its flag");

   a_flag_upper: assert property (                              // [R05]
      @(posedge i_mclk) disable iff (i_reset)
      (i_ce && i_rd && sel == etcu_pkg::ETCU_REG_FLAGS)
      |=> o_rdata[7:4] == 4'h0 && o_rdata[3:0] == $past(flag_r))
      else $error("flag read wrong");

   a_read_clear: assert property (                              // [R06]
      @(posedge i_mclk) disable iff (i_reset)
      (i_ce && i_rd && sel == etcu_pkg::ETCU_REG_A_FALL && !event_w[1])
      |=> !flag_r[1] && (flag_r[0] || !$past(flag_r[0]))
          && (flag_r[3:2] & $past(flag_r[3:2])) == $past(flag_r[3:2]))
      else $error("time read cleared wrong flags");

   a_hold_keep: assert property (                               // [R07] [R09]
      @(posedge i_mclk) disable iff (i_reset)
      (cfg_r.hold && flag_r[1] && !rd_clr[1]) [*2] |-> $stable(cap_r[1]))
      else $error("held time overwritten before read");

   a_latest_edge: assert property (                             // [R08]
      @(posedge i_mclk) disable iff (i_reset)
      (i_ce && !cfg_r.hold && event_w[2]) |=> cap_r[2] == $past(slice_w))
      else $error("latest edge did not overwrite");

   a_irq_raise: assert property (                               // [R11] [R12]
      @(posedge i_mclk) disable iff (i_reset)
      (i_ce && flag_r[0] && cfg_r.int_en[0] && i_global_ie[4])
      |=> o_irq_a)
      else $error("enabled a event gave no request");

   a_irq_gate: assert property (                                // [R12] [R15]
      @(posedge i_mclk) disable iff (i_reset)
      (i_ce && !i_global_ie[`ETCU_GIE_B_BIT]) |=> !o_irq_b)
      else $error("b request without global enable");

   a_irq_gate_a: assert property (                              // [R12] [R15]
      @(posedge i_mclk) disable iff (i_reset)
      (i_ce && !i_global_ie[`ETCU_GIE_A_BIT]) |=> !o_irq_a)
      else $error("a request without global enable");

   a_irq_raise_b: assert property (                             // [R11]
      @(posedge i_mclk) disable iff (i_reset)
      (i_ce && flag_r[3] && cfg_r.int_en[3]
       && i_global_ie[`ETCU_GIE_B_BIT]) |=> o_irq_b)
      else $error("enabled b event gave no request");

   a_irq_mask_a: assert property (                              // [R10]
      @(posedge i_mclk) disable iff (i_reset)
      (i_ce && (flag_r[1:0] & cfg_r.int_en[1:0]) == 2'h0) |=> !o_irq_a)
      else $error("a request without an enabled event");

   a_cfg_write: assert property (                               // [R10]
      @(posedge i_mclk) disable iff (i_reset)
      (i_ce && i_wr && sel == etcu_pkg::ETCU_REG_CFG)
      |=> cfg_r == $past(i_wdata))
      else $error("config write not taken");

   a_read_clear_b: assert property (                            // [R06]
      @(posedge i_mclk) disable iff (i_reset)
      (i_ce && i_rd && sel == etcu_pkg::ETCU_REG_B_RISE && !event_w[2])
      |=> !flag_r[2])
      else $error("b rise read left its flag set");

   a_time_read: assert property (                               // [R02]
      @(posedge i_mclk) disable iff (i_reset)
      (i_ce && i_rd && sel == etcu_pkg::ETCU_REG_B_FALL)
      |=> o_rdata == $past(cap_r[3]))
      else $error("b fall read returned wrong time");

   a_hold_block: assert property (                              // [R07] [R09]
      @(posedge i_mclk) disable iff (i_reset)
      (i_ce && cfg_r.hold && flag_r[0] && event_w[0]) |=> $stable(cap_r[0]))
      else $error("held a rise time overwritten");

   c_prescale_high: cover property (
      @(posedge i_mclk) disable iff (i_reset)
      i_ce && cap_ok[3] && cfg_r.prescale > `ETCU_PS_DIV16);

   c_irq_a: cover property (
      @(posedge i_mclk) disable iff (i_reset)
      o_irq_a && flag_r[1]);

   c_hold_capture: cover property (
      @(posedge i_mclk) disable iff (i_reset)
      cfg_r.hold && event_w[0] && flag_r[0]);

   c_read_and_event: cover property (
      @(posedge i_mclk) disable iff (i_reset)
      i_ce && rd_clr[0] && event_w[0]);

   c_irq_b: cover property (
      @(posedge i_mclk) disable iff (i_reset)
      o_irq_b && flag_r[3]);

endmodule : etcu_top

`default_nettype wire

/* bench/etcu_pin_model.sv */
`timescale 1ns/100ps
`default_nettype none

module etcu_pin_model (
   // clock
   input  wire logic       i_mclk,
   // capture pins, bit 0 channel a, bit 1 channel b
   output var  logic [1:0] o_pin
);

   // ****************************************
   // pin driver
   // ****************************************
   initial begin
      o_pin = 2'h0;
   end

   // flip one pin just after a clock edge, then keep the level; levels
   // shorter than two cycles could slip past the synchroniser
   task automatic toggle(input int ch, input int hold_cyc);
      @(posedge i_mclk);
      o_pin[ch] <= ~o_pin[ch];
      repeat ((hold_cyc < 2) ? 2 : hold_cyc) @(posedge i_mclk);
   endtask : toggle

endmodule : etcu_pin_model

`default_nettype wire

/* bench/test_edge_time_capture_unit.sv */
`timescale 1ns/100ps
`default_nettype none

module test_edge_time_capture_unit;

   // ****************************************
   // signals
   // ****************************************
   logic        i_mclk;
   logic        i_reset;
   logic        i_ce;
   logic [1:0]  i_pin;
   logic [11:0] i_timer;
   logic [7:0]  i_global_ie;
   logic [7:0]  i_addr;
   logic [7:0]  i_wdata;
   logic        i_wr;
   logic        i_rd;
   logic [7:0]  o_rdata;
   logic        o_irq_a;
   logic        o_irq_b;
   int          num_errors;
   int          comparisons;
   int          cycles;
   logic [7:0]  k_ofs;

   etcu_top u_dut (
      .i_mclk      (i_mclk),
      .i_reset     (i_reset),
      .i_ce        (i_ce),
      .i_pin       (i_pin),
      .i_timer     (i_timer),
      .i_global_ie (i_global_ie),
      .i_addr      (i_addr),
      .i_wdata     (i_wdata),
      .i_wr        (i_wr),
      .i_rd        (i_rd),
      .o_rdata     (o_rdata),
      .o_irq_a     (o_irq_a),
      .o_irq_b     (o_irq_b)
   );

   etcu_pin_model u_src (
      .i_mclk (i_mclk),
      .o_pin  (i_pin)
   );

   // ****************************************
   // clock, reset, timeout
   // ****************************************
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         end_of_test();
      end
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr    <= 1'b0;
   endtask : reg_wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_mclk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd   <= 1'b0;
      #1;
      check($sformatf("register %h", a), o_rdata, exp);
   endtask : rd_chk

   // set the timer, then make edge idx (a rise, a fall, b rise, b fall)
   task automatic ev(input int idx, input logic [11:0] t, input int hold);
      @(posedge i_mclk);
      i_timer <= t;
      u_src.toggle(idx / 2, hold);
   endtask : ev

   task automatic irq_chk(input logic a, input logic b);
      check("irq a", {7'h0, o_irq_a}, {7'h0, a});
      check("irq b", {7'h0, o_irq_b}, {7'h0, b});
   endtask : irq_chk

   function automatic logic [7:0] slice(input logic [11:0] t,
                                        input logic [2:0]  ps);
      return 8'(t >> ((ps > 3'h4) ? 3'h4 : ps));
   endfunction : slice

   task automatic hold_case(input logic hold);
      k_ofs = hold ? 8'h00 : 8'h20;
      reg_wr(8'h44, {hold, 7'h00});
      for (int j = 0; j < 4; j++) begin
         ev(j % 2, 12'h010 + 12'(j * 16), (j < 2) ? 6 : 4);
         ev(2 + j % 2, 12'h050 + 12'(j * 16), 4);
      end
      rd_chk(8'h45, 8'h0f);
      rd_chk(8'h40, 8'h10 + k_ofs);
      rd_chk(8'h45, 8'h0e);
      rd_chk(8'h41, 8'h20 + k_ofs);
      rd_chk(8'h42, 8'h50 + k_ofs);
      rd_chk(8'h43, 8'h60 + k_ofs);
      rd_chk(8'h45, 8'h00);
      ev(0, 12'h0c3, 6);
      ev(1, 12'h0d4, 6);
      rd_chk(8'h40, 8'hc3);
      rd_chk(8'h41, 8'hd4);
      $display("test hold %0d done", hold);
   endtask : hold_case

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      i_reset     = 1'b1;
      i_ce        = 1'b1;
      i_timer     = 12'h000;
      i_global_ie = 8'h00;
      i_addr      = 8'h00;
      i_wdata     = 8'h00;
      i_wr        = 1'b0;
      i_rd        = 1'b0;
      repeat (2) @(posedge i_mclk);
      i_reset <= 1'b0;
      repeat (4) @(posedge i_mclk);
      for (int a = 0; a < 7; a++) begin
         rd_chk(8'h40 + 8'(a), 8'h00);
      end
      irq_chk(1'b0, 1'b0);
      reg_wr(8'h44, 8'h5a);
      rd_chk(8'h44, 8'h5a);
      // strobes are ignored while the clock enable is low
      @(posedge i_mclk);
      i_ce <= 1'b0;
      reg_wr(8'h44, 8'h11);
      i_ce <= 1'b1;
      rd_chk(8'h44, 8'h5a);
      reg_wr(8'h40, 8'hff);
      reg_wr(8'h42, 8'hff);
      reg_wr(8'h43, 8'hff);
      reg_wr(8'h45, 8'hff);
      reg_wr(8'h46, 8'hff);
      rd_chk(8'h40, 8'h00);
      rd_chk(8'h42, 8'h00);
      rd_chk(8'h43, 8'h00);
      rd_chk(8'h45, 8'h00);
      $display("test registers done");

      for (int i = 0; i < 8; i++) begin
         reg_wr(8'h44, {1'b0, 3'(i), 4'h0});
         ev(i % 4, 12'ha5c + 12'(i * 37), 6);
         rd_chk(8'h45, 8'h01 << (i % 4));
         rd_chk(8'h40 + 8'(i % 4),
                slice(12'ha5c + 12'(i * 37), 3'(i)));
         rd_chk(8'h45, 8'h00);
      end
      $display("test prescale done");

      hold_case(1'b1);
      hold_case(1'b0);

      for (int k = 0; k < 4; k++) begin
         reg_wr(8'h44, 8'h01 << k);
         i_global_ie <= (k < 2) ? 8'h20 : 8'h10;
         ev(k, 12'h0a0, 8);
         #1;
         irq_chk(1'b0, 1'b0);
         @(posedge i_mclk);
         i_global_ie <= 8'h30;
         repeat (3) @(posedge i_mclk);
         #1;
         irq_chk(k < 2, k >= 2);
         reg_wr(8'h44, 8'h00);
         repeat (2) @(posedge i_mclk);
         #1;
         irq_chk(1'b0, 1'b0);
         rd_chk(8'h40 + 8'(k), 8'ha0);
         @(posedge i_mclk);
         i_global_ie <= 8'h00;
      end
      $display("test interrupts done");

      // mid-run reset with a request up and pin a left high
      reg_wr(8'h44, 8'hf3);
      i_global_ie <= 8'h30;
      ev(0, 12'h0b7, 6);
      #1;
      irq_chk(1'b1, 1'b0);
      @(posedge i_mclk);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_reset <= 1'b0;
      repeat (4) @(posedge i_mclk);
      for (int a = 0; a < 6; a++) begin
         rd_chk(8'h40 + 8'(a), 8'h00);
      end
      irq_chk(1'b0, 1'b0);
      $display("test reset done");
      end_of_test();
   end

endmodule : test_edge_time_capture_unit

`default_nettype wire
